//--- rtl/fcm_pkg.sv
// Purpose: shared constants and types for the control-plane symbol/frequency mapper link
// Assumes: one 20 MHz clock, both ends in one clock domain
// Notes: message fields travel as one parsed header word per message
package fcm_pkg;
	// ==========================================
	// encapsulation and message kinds
	localparam logic [0:0] ENC_ECPRI        = 1'h0;
	localparam logic [0:0] ENC_RADIO_OVER_E = 1'h1;
	localparam logic [0:0] DIR_UL           = 1'h0;
	localparam logic [0:0] DIR_DL           = 1'h1;
	localparam logic [3:0] SCS_1K25         = 4'hC;
	localparam logic [3:0] SCS_15K          = 4'h0;
	localparam logic [31:0] SCS_HZ_15K      = 32'h0000_3A98;
	localparam logic [31:0] SCS_HZ_1K25     = 32'h0000_04E2;
	// ==========================================
	// symbol mapping
	localparam logic [3:0] NR_LAST_SYM_NCP  = 4'hD;
	localparam logic [3:0] NR_LAST_SYM_ECP  = 4'hB;
	localparam logic [3:0] LEG_ODD_OFS_NCP  = 4'h7;
	localparam logic [3:0] LEG_ODD_OFS_ECP  = 4'h6;
	localparam logic [3:0] SC_PER_PRB       = 4'hC;
	// symbol durations in ns at 15 kHz, scaled down by numerology
	localparam int         SYM_NS_NCP_15K   = 71354;
	localparam int         SYM_NS_ECP_15K   = 83333;
	localparam int         SYM_NS_LEG_15K   = 71354;
	localparam int         CLK_NS           = 50;
	localparam int         SYM_CYC_NCP_15K  = SYM_NS_NCP_15K / CLK_NS;
	localparam int         SYM_CYC_ECP_15K  = SYM_NS_ECP_15K / CLK_NS;
	localparam int         SYM_CYC_LEG_15K  = SYM_NS_LEG_15K / CLK_NS;
	// ==========================================
	// apb register map of the controller
	localparam logic [7:0] REG_CTRL         = 8'h00;
	localparam logic [7:0] REG_SLOT         = 8'h04;
	localparam logic [7:0] REG_PRB          = 8'h08;
	localparam logic [7:0] REG_FREQ         = 8'h0C;
	localparam logic [7:0] REG_STATUS       = 8'h10;
	localparam logic [7:0] REG_DEADLINE     = 8'h14;
	localparam logic [31:0] REG_RESET_VAL   = 32'h0000_0000;
	localparam int          CTRL_GO_BIT     = 0;

	typedef struct packed {
		logic        enc;         // framing used
		logic        dir;         // downlink or uplink
		logic        legacy;      // legacy 4G carrier
		logic        ext_cp;      // extended cyclic prefix
		logic [3:0]  scs;         // frameStructure spacing code
		logic        ssb;         // sync-block channel
		logic [7:0]  slot;        // slot as sent
		logic [3:0]  start_sym;   // startSymbolId
		logic [9:0]  start_prbc;
		logic [9:0]  num_prbc;
		logic [23:0] freq_offset; // signed, half-spacing units
		logic [7:0]  sections;    // number of section descriptions
		logic [15:0] deadline;    // cycles left before the earliest symbol's deadline
	} fcm_msg_t;
endpackage

//--- rtl/fcm_link_if.sv
// Purpose: control-plane flow between distributed unit and radio unit
// Assumes: shared clk, valid/ready handshake, one message per beat
// Notes: separate from any user-plane flow
`timescale 1ns/1ps
interface fcm_link_if (input wire logic clk);
	logic              cp_valid;
	logic              cp_ready;
	logic              cp_is_user;
	fcm_pkg::fcm_msg_t cp_msg;
	modport du (output cp_valid, output cp_is_user, output cp_msg, input cp_ready);
	modport ru (input cp_valid, input cp_is_user, input cp_msg, output cp_ready);
endinterface

//--- rtl/fcm_du_ctrl.sv
// Purpose: baseband distributed unit end, builds control messages from apb registers
// Assumes: apb slave with zero wait states
// Notes: software fills slot, prb and freq registers then writes go
`timescale 1ns/1ps
module fcm_du_ctrl (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       psel,
	input  wire logic       penable,
	input  wire logic       pwrite,
	input  wire logic [7:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]     prdata,
	output logic            pready,
	output logic            pslverr,
	fcm_link_if.du          link
);
	typedef struct packed {
		logic [31:0]       ctrl;
		logic [31:0]       slot;
		logic [31:0]       prb;
		logic [31:0]       freq;
		logic [31:0]       dline;
		logic              busy;
		logic [15:0]       sent;
		fcm_pkg::fcm_msg_t msg;
		logic [31:0]       rdata;
		logic              err;
	} fcm_du_t;
	fcm_du_t s_q;
	fcm_du_t s_d;
	logic    wr;
	logic    rd;
	// ==========================================
	// apb slave and message build
	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	always_comb
	begin
		s_d = s_q;
		if (wr)
		begin
			case (paddr)
				fcm_pkg::REG_CTRL:     s_d.ctrl = pwdata;
				fcm_pkg::REG_SLOT:     s_d.slot = pwdata;
				fcm_pkg::REG_PRB:      s_d.prb = pwdata;
				fcm_pkg::REG_FREQ:     s_d.freq = pwdata;
				fcm_pkg::REG_DEADLINE: s_d.dline = pwdata;
				default:               s_d.ctrl = s_q.ctrl;
			endcase
		end
		if (rd)
		begin
			s_d.err = 1'b0;
			case (paddr)
				fcm_pkg::REG_CTRL:     s_d.rdata = s_q.ctrl;
				fcm_pkg::REG_SLOT:     s_d.rdata = s_q.slot;
				fcm_pkg::REG_PRB:      s_d.rdata = s_q.prb;
				fcm_pkg::REG_FREQ:     s_d.rdata = s_q.freq;
				fcm_pkg::REG_DEADLINE: s_d.rdata = s_q.dline;
				fcm_pkg::REG_STATUS:   s_d.rdata = {15'h0000, s_q.busy, s_q.sent};
				default:
				begin
					s_d.rdata = 32'h0000_0000;
					s_d.err   = 1'b1;
				end
			endcase
		end
		// one direction per message: dir comes from a single ctrl bit
		if (!s_q.busy && s_q.ctrl[fcm_pkg::CTRL_GO_BIT])
		begin
			s_d.busy             = 1'b1;
			// a go written in the same cycle survives and is served next
			if (!(wr && paddr == fcm_pkg::REG_CTRL))
				s_d.ctrl[fcm_pkg::CTRL_GO_BIT] = 1'b0;
			s_d.msg.enc          = s_q.ctrl[1];
			s_d.msg.dir          = s_q.ctrl[2];
			s_d.msg.legacy       = s_q.ctrl[3];
			s_d.msg.ext_cp       = s_q.ctrl[4];
			s_d.msg.ssb          = s_q.ctrl[5];
			s_d.msg.scs          = s_q.ctrl[11:8];
			s_d.msg.sections     = s_q.ctrl[23:16];
			s_d.msg.slot         = s_q.slot[7:0];
			s_d.msg.start_sym    = s_q.slot[11:8];
			// prach block lower guard tone addressed by start/num prbc
			s_d.msg.start_prbc   = s_q.prb[9:0];
			s_d.msg.num_prbc     = s_q.prb[25:16];
			s_d.msg.freq_offset  = s_q.freq[23:0];
			// software supplies the remaining lead; late sends are its choice
			s_d.msg.deadline     = s_q.dline[15:0];
		end
		if (s_q.busy && link.cp_ready)
		begin
			s_d.busy = 1'b0;
			s_d.sent = s_q.sent + 16'h0001;
		end
	end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end
	assign prdata          = s_q.rdata;
	assign pready          = 1'b1;
	assign pslverr         = s_q.err && psel && penable;
	assign link.cp_valid   = s_q.busy;
	assign link.cp_is_user = 1'b0;
	assign link.cp_msg     = s_q.msg;
endmodule

//--- rtl/fcm_ru_mapper.sv
// Purpose: radio unit end, maps control-plane symbols and frequencies
// Assumes: carrier centre and sync offset come from management inputs
// Notes: one message accepted per cycle, results registered
//        pusch spacing sets the prach guard margin of the filter
`timescale 1ns/1ps
module fcm_ru_mapper (
	input  wire logic        clk,
	input  wire logic        rst,
	fcm_link_if.ru           link,
	input  wire logic [31:0] carrier_center_hz,
	input  wire logic [23:0] ssb_freq_offset,
	input  wire logic [3:0]  pusch_scs,
	input  wire logic        late_clear,
	output logic             map_valid,
	output logic             map_dir,
	output logic [7:0]       map_slot,
	output logic [3:0]       map_symbol,
	output logic [3:0]       map_scs,
	output logic [17:0]      map_sym_cycles,
	output logic [31:0]      filter_center_hz,
	output logic [31:0]      filter_pass_hz,
	output logic [7:0]       sections_seen,
	output logic             bad_symbol,
	output logic             late_flag,
	output logic [15:0]      late_count,
	output logic             user_dropped
);
	// ==========================================
	// registered state and working signals
	typedef struct packed {
		logic        valid;
		logic        dir;
		logic [7:0]  slot;
		logic [3:0]  sym;
		logic [3:0]  scs;
		logic [17:0] cyc;
		logic [31:0] fc;
		logic [31:0] pass;
		logic [7:0]  secs;
		logic        bad;
		logic        late;
		logic [15:0] lcnt;
		logic        udrop;
	} fcm_ru_t;
	fcm_ru_t            s_q;
	fcm_ru_t            s_d;
	fcm_pkg::fcm_msg_t  m;
	logic               take;
	logic [3:0]         eff_scs;
	logic [3:0]         last_sym;
	logic [31:0]        sc_hz;
	logic [31:0]        half_hz;
	logic signed [47:0] ofs_hz;
	logic [31:0]        prb_hz;
	logic [17:0]        base_cyc;
	logic [23:0]        ofs_sel;
	logic [31:0]        ofs_term;
	logic [31:0]        start_term;
	logic [31:0]        span_hz;
	logic [31:0]        pusch_hz;
	logic [31:0]        guard_hz;
	logic               prach;
	logic [7:0]         mapped_slot;
	logic [3:0]         mapped_sym;
	logic               user_beat;
	logic               late_now;
	assign m    = link.cp_msg;
	assign link.cp_ready = 1'b1;
	// ==========================================
	// flow separation
	// a user beat here means the flows were mixed upstream; it is dropped, never mapped
	assign user_beat = link.cp_valid && link.cp_is_user;
	// both framings accepted, user-plane beats never enter mapping
	assign take      = link.cp_valid && !link.cp_is_user;
	// lead time used up at arrival means the message is late
	assign late_now  = take && (m.deadline == 16'h0000);
	// ==========================================
	// spacing and frequency arithmetic
	always_comb
	begin
		// sub-15 kHz prach spacing still counts symbols at 15 kHz
		eff_scs = (m.scs == fcm_pkg::SCS_1K25) ? fcm_pkg::SCS_15K : m.scs;
		case (m.scs)
			fcm_pkg::SCS_1K25: sc_hz = fcm_pkg::SCS_HZ_1K25;
			default:           sc_hz = fcm_pkg::SCS_HZ_15K << m.scs[2:0];
		endcase
		half_hz = sc_hz >> 1;
		// centre is the one reference; sync uses its own offset
		ofs_sel    = m.ssb ? ssb_freq_offset : m.freq_offset;
		ofs_hz     = $signed(ofs_sel) * $signed({1'b0, half_hz[22:0]});
		prb_hz     = sc_hz * 32'(fcm_pkg::SC_PER_PRB);
		ofs_term   = ofs_hz[31:0];
		start_term = 32'(m.start_prbc) * prb_hz;
		span_hz    = 32'(m.num_prbc) * prb_hz;
		last_sym = m.ext_cp ? fcm_pkg::NR_LAST_SYM_ECP : fcm_pkg::NR_LAST_SYM_NCP;
		if (m.legacy)
			base_cyc = 18'(fcm_pkg::SYM_CYC_LEG_15K);
		else if (m.ext_cp)
			base_cyc = 18'(fcm_pkg::SYM_CYC_ECP_15K);
		else
			base_cyc = 18'(fcm_pkg::SYM_CYC_NCP_15K);
	end
	// ==========================================
	// prach filter guard on the pusch grid
	// guard tones sit on the pusch grid, so the passband keeps one pusch tone of margin
	// at each edge: a little less rejection, but the edge tones are never clipped
	always_comb
	begin
		pusch_hz = fcm_pkg::SCS_HZ_15K << pusch_scs[2:0];
		prach    = (m.scs == fcm_pkg::SCS_1K25);
		if (prach)
			guard_hz = pusch_hz << 1;
		else
			guard_hz = 32'h0000_0000;
	end
	// ==========================================
	// symbol mapping onto the new radio slot
	// a legacy slot pair folds into one slot; the odd half lands after the even one
	always_comb
	begin
		mapped_slot = m.slot;
		mapped_sym  = m.start_sym;
		if (m.legacy)
		begin
			mapped_slot = {1'b0, m.slot[7:1]};
			if (m.slot[0] && m.ext_cp)
				mapped_sym = m.start_sym + fcm_pkg::LEG_ODD_OFS_ECP;
			else if (m.slot[0])
				mapped_sym = m.start_sym + fcm_pkg::LEG_ODD_OFS_NCP;
		end
	end
	// ==========================================
	// message capture
	always_comb
	begin
		s_d       = s_q;
		s_d.valid = 1'b0;
		s_d.udrop = user_beat;
		if (take)
		begin
			s_d.valid = 1'b1;
			s_d.dir   = m.dir;
			s_d.scs   = eff_scs;
			s_d.cyc   = base_cyc >> eff_scs[2:0];
			s_d.secs  = m.sections;
			s_d.slot  = mapped_slot;
			s_d.sym   = mapped_sym;
			s_d.bad   = m.legacy ? 1'b0 : (m.start_sym > last_sym);
			// block grid: offset locates element 0 of block 0, start counts from it;
			// the centre sits mid-span so the filter is symmetric about the blocks sent
			s_d.fc    = carrier_center_hz + ofs_term + start_term + (span_hz >> 1);
			// passband follows the count given, guard blocks included or not
			s_d.pass  = span_hz + guard_hz;
		end
		// set wins over clear
		if (late_now)
		begin
			s_d.late = 1'b1;
			s_d.lcnt = s_q.lcnt + 16'h0001;
		end
		else if (late_clear)
			s_d.late = 1'b0;
	end
	// ==========================================
	// state register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end
	// ==========================================
	// outputs
	assign map_valid        = s_q.valid;
	assign map_dir          = s_q.dir;
	assign map_slot         = s_q.slot;
	assign map_symbol       = s_q.sym;
	assign map_scs          = s_q.scs;
	assign map_sym_cycles   = s_q.cyc;
	assign filter_center_hz = s_q.fc;
	assign filter_pass_hz   = s_q.pass;
	assign sections_seen    = s_q.secs;
	assign bad_symbol       = s_q.bad;
	assign late_flag        = s_q.late;
	assign late_count       = s_q.lcnt;
	assign user_dropped     = s_q.udrop;
endmodule

//--- bench/fcm_link_asserts.sv
// Purpose: link checks between the two ends
// Assumes: one clock, reset async active high
// Notes: sees the link signals only
`timescale 1ns/1ps
module fcm_link_asserts (
	input wire logic              clk,
	input wire logic              rst,
	input wire logic              cp_valid,
	input wire logic              cp_ready,
	input wire logic              cp_is_user,
	input wire fcm_pkg::fcm_msg_t cp_msg
);
	// ==========================================
	// link properties
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	a_user_never: assert property (!cp_is_user)
		else $error("user beat on control flow");
	a_ready_up: assert property (cp_ready)
		else $error("mapper not ready");
	a_beat_taken: assert property (cp_valid |-> cp_ready)
		else $error("beat not taken");
	a_beat_gap: assert property (cp_valid |=> !cp_valid[*2])
		else $error("beats closer than one go allows");
	a_msg_hold: assert property (cp_valid |=> $stable(cp_msg))
		else $error("message changed after beat");
	a_start_quiet: assert property ($fell(rst) |-> !cp_valid[*3])
		else $error("beat without a go");
	a_ready_start: assert property ($fell(rst) |-> cp_ready ##1 cp_ready)
		else $error("not ready after reset");
	a_user_start: assert property ($fell(rst) |-> !cp_is_user[*2])
		else $error("user flag after reset");
endmodule

//--- bench/fronthaul_cplane_symbol_freq_mapper_tb.sv
// Purpose: bench for the du controller and ru mapper pair
// Assumes: apb answer is taken when pready is high
// Notes: expected figures worked from a 3.5 GHz centre
`timescale 1ns/1ps
module fronthaul_cplane_symbol_freq_mapper_tb;
	logic        clk, rst, psel, penable, pwrite, late_clear, pready, pslverr, err;
	logic        map_valid, map_dir, bad_symbol, late_flag, udrop;
	logic [7:0]  paddr, map_slot, sections_seen;
	logic [3:0]  map_symbol, map_scs, pusch_scs;
	logic [17:0] map_sym_cycles;
	logic [31:0] pwdata, prdata, rd, fc, ctr, pass;
	logic [23:0] ssb_ofs;
	logic [15:0] late_count;
	int          fails, n_tests;
	fcm_link_if link (.clk(clk));
	fcm_du_ctrl fcm_du_ctrl_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .link(link.du));
	fcm_ru_mapper fcm_ru_mapper_inst (.clk, .rst, .link(link.ru), .carrier_center_hz(ctr),
		.ssb_freq_offset(ssb_ofs), .pusch_scs(pusch_scs), .late_clear, .map_valid, .map_dir, .map_slot,
		.map_symbol, .map_scs, .map_sym_cycles, .filter_center_hz(fc), .filter_pass_hz(pass),
		.sections_seen, .bad_symbol, .late_flag, .late_count, .user_dropped(udrop));
	fcm_link_asserts fcm_link_asserts_inst (.clk, .rst, .cp_valid(link.cp_valid),
		.cp_ready(link.cp_ready), .cp_is_user(link.cp_is_user), .cp_msg(link.cp_msg));
	// ==========================================
	// tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// request held until the rising edge that sees pready; data and error taken at that edge
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		psel    <= 1'h1;
		penable <= 1'h0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1)
			@(posedge clk);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	task send(input logic [31:0] c, s, p, f, d);
		apb(fcm_pkg::REG_SLOT, 1'h1, s);
		apb(fcm_pkg::REG_PRB, 1'h1, p);
		apb(fcm_pkg::REG_FREQ, 1'h1, f);
		apb(fcm_pkg::REG_DEADLINE, 1'h1, d);
		apb(fcm_pkg::REG_CTRL, 1'h1, c | 32'h1);
		for (int i = 0; i < 20 && map_valid !== 1'h1; i++)
			@(negedge clk);
		chk(map_valid, 32'h1);
		@(posedge clk);
	endtask
	task ms(input logic [31:0] s, y, b);
		chk(map_slot, s);
		chk(map_symbol, y);
		chk(bad_symbol, b);
	endtask
	task final_report();
		$display("fails %0d n_tests %0d", fails, n_tests);
		if (fails == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ==========================================
	// clock, watchdog and tests
	initial
	begin
		clk = 1'h0;
		forever
			#25 clk = ~clk;
	end
	initial
	begin
		#200000;
		fails++;
		final_report();
	end
	initial
	begin
		rst        = 1'h1;
		psel       = 1'h0;
		penable    = 1'h0;
		pwrite     = 1'h0;
		paddr      = 8'h00;
		pwdata     = 32'h0;
		late_clear = 1'h0;
		ctr        = 32'hD09D_C300;
		ssb_ofs    = 24'h00_000A;
		pusch_scs  = 4'h1;
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		send(32'h0003_0104, 32'h0D09, 32'h0048_0002, 32'h00FF_FF9C, 32'h5);
		ms(9, 13, 0);
		chk(map_dir, 1);
		chk(sections_seen, 3);
		chk(map_sym_cycles, fcm_pkg::SYM_CYC_NCP_15K >> 1);
		chk(fc, ctr - 32'd1500000 + 32'd720000 + 32'd12960000);
		chk(late_flag, 0);
		chk(map_scs, 32'h1);
		chk(pass, 32'h0000_0048 * 32'(fcm_pkg::SC_PER_PRB) * (fcm_pkg::SCS_HZ_15K << 1));
		chk(udrop, 0);
		send(32'h0001_0102, 32'h0009, 32'h0047_0002, 32'h00FF_FF9C, 32'h5);
		chk(map_dir, 0);
		chk(fc, ctr - 32'd1500000 + 32'd720000 + 32'd12780000);
		send(32'h0001_0000, 32'h0E00, 32'h0001_0000, 32'h0, 32'h5);
		ms(0, 14, 1);
		send(32'h0001_0010, 32'h0B03, 32'h0001_0000, 32'h0, 32'h5);
		ms(3, 11, 0);
		chk(map_sym_cycles, fcm_pkg::SYM_CYC_ECP_15K);
		send(32'h0001_0010, 32'h0C03, 32'h0001_0000, 32'h0, 32'h5);
		chk(bad_symbol, 1);
		send(32'h0001_0008, 32'h0305, 32'h0001_0000, 32'h0, 32'h5);
		ms(2, 10, 0);
		chk(map_sym_cycles, fcm_pkg::SYM_CYC_LEG_15K);
		send(32'h0001_0008, 32'h0304, 32'h0001_0000, 32'h0, 32'h5);
		ms(2, 3, 0);
		send(32'h0001_0018, 32'h0203, 32'h0001_0000, 32'h0, 32'h5);
		ms(1, 8, 0);
		send(32'h0001_0C00, 32'h0000, 32'h0001_0000, 32'h0, 32'h5);
		chk(map_sym_cycles, fcm_pkg::SYM_CYC_NCP_15K);
		chk(map_scs, fcm_pkg::SCS_15K);
		chk(pass, 32'(fcm_pkg::SC_PER_PRB) * fcm_pkg::SCS_HZ_1K25 + ((fcm_pkg::SCS_HZ_15K << 1) << 1));
		// the message offset must be ignored here, the sync offset rules
		send(32'h0001_0020, 32'h0000, 32'h0014_0000, 32'h64, 32'h0);
		chk(fc, ctr + 32'd75000 + 32'd1800000);
		chk(late_flag, 1);
		chk(late_count, 1);
		late_clear <= 1'h1;
		@(posedge clk);
		late_clear <= 1'h0;
		@(negedge clk);
		chk(late_flag, 0);
		chk(late_count, 1);
		@(posedge clk);
		apb(fcm_pkg::REG_STATUS, 1'h0, 32'h0);
		chk(rd[16:0], 32'd10);
		apb(fcm_pkg::REG_CTRL, 1'h0, 32'h0);
		chk(rd[0], 0);
		apb(8'h18, 1'h0, 32'h0);
		chk(err, 1);
		final_report();
	end
endmodule
